// ===== core/sbp_pkg.sv
// Shared constants and types for the system bus pin block
package sbp_pkg;

    // Bus widths
    localparam int ADDR_W     = 23;   // Significant word address bits
    localparam int PIN_ADDR_W = 31;   // Address pins above the byte select
    localparam int PAD_W      = PIN_ADDR_W - ADDR_W;
    localparam int DATA_W     = 32;
    localparam int HALF_W     = 16;
    localparam int SEL_W      = 6;

    // Data phase length of a master cycle, in clock cycles
    localparam logic [1:0] DATA_WAIT = 2'h2;

    // Values after reset
    localparam logic RST_MODE_BIG = 1'b0;
    localparam logic RST_AS_BIG   = 1'b1;   // Strobe idles high in big endian convention
    localparam logic RST_ADS      = 1'b0;   // Strobe idles low in little endian convention

    // Master cycle phases, Gray coded along the usual path
    typedef enum logic [1:0] {
        SBP_IDLE = 2'b00,
        SBP_ADDR = 2'b01,
        SBP_DATA = 2'b11,
        SBP_END  = 2'b10
    } sbp_phase_t;

    // State of the main pin block
    typedef struct packed {
        logic                  mode_s1;
        logic                  mode_s2;
        logic                  mode_big;
        logic [SEL_W-1:0]      sel_s1;
        logic [SEL_W-1:0]      sel_s2;
        logic                  rd_s1;
        logic                  rd_s2;
        logic [DATA_W-1:0]     din_s1;
        logic [DATA_W-1:0]     din_s2;
        sbp_phase_t            phase;
        logic [1:0]            wait_cnt;
        logic                  is_write;
        logic                  is_wide;
        logic [PIN_ADDR_W-1:0] addr;
        logic                  addr_oe;
        logic [DATA_W-1:0]     dout;
        logic                  lo_oe;
        logic                  hi_oe;
        logic [SEL_W-1:0]      reg_index;
        logic [DATA_W-1:0]     rdata;
        logic                  done;
    } sbp_core_t;

    // State of the strobe generator
    typedef struct packed {
        logic as_big;
        logic as_big_oe;
        logic address_valid_strobe_little;
        logic ads_oe;
        logic mem_direction_read_high;
        logic mrw_oe;
        logic mem_direction_write_high;
        logic mwr_oe;
    } sbp_strb_t;

endpackage

// ===== core/sbp_strb_if.sv
// Carrier between the cycle sequencer and the strobe generator
`timescale 1ns/100ps
interface sbp_strb_if;
    logic mode_big;
    logic owned;
    logic addr_valid;
    logic is_write;

    modport ctl (output mode_big, output owned, output addr_valid, output is_write);
    modport gen (input mode_big, input owned, input addr_valid, input is_write);
endinterface

// ===== core/sbp_strobe_gen.sv
// Address strobe and memory direction pin generator
`timescale 1ns/100ps
module sbp_strobe_gen (
    input  wire logic    i_sys_clk,
    input  wire logic    i_reset,
    sbp_strb_if.gen      strb,
    output logic         o_address_valid_strobe_big,
    output logic         o_address_valid_strobe_big_oe,
    output logic         o_address_valid_strobe_little,
    output logic         o_address_valid_strobe_little_oe,
    output logic         o_mem_direction_read_high,
    output logic         o_mem_direction_read_high_oe,
    output logic         o_mem_direction_write_high,
    output logic         o_mem_direction_write_high_oe
);

    sbp_pkg::sbp_strb_t r;
    sbp_pkg::sbp_strb_t n;

    // Pin values per convention, driven only while the bus is held
    always_comb begin
        n           = r;
        n.as_big_oe = strb.owned && strb.mode_big;           // see [RULE2]
        n.ads_oe    = strb.owned && !strb.mode_big;          // see [RULE2]
        n.mrw_oe    = strb.owned && strb.mode_big;           // see [RULE11]
        n.mwr_oe    = strb.owned && !strb.mode_big;          // see [RULE11]
        n.as_big    = !(strb.owned && strb.addr_valid);      // see [RULE8] [RULE9]
        n.address_valid_strobe_little       = strb.owned && strb.addr_valid;         // see [RULE10]
        n.mem_direction_read_high       = !strb.is_write;                        // see [RULE12]
        n.mem_direction_write_high       = strb.is_write;                         // see [RULE13]
    end

    // State register
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            r <= '{as_big: sbp_pkg::RST_AS_BIG, as_big_oe: 1'b0,
                   address_valid_strobe_little: sbp_pkg::RST_ADS, ads_oe: 1'b0,
                   mem_direction_read_high: 1'b0, mrw_oe: 1'b0, mem_direction_write_high: 1'b0, mwr_oe: 1'b0};
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state
    assign o_address_valid_strobe_big       = r.as_big;
    assign o_address_valid_strobe_big_oe    = r.as_big_oe;
    assign o_address_valid_strobe_little    = r.address_valid_strobe_little;
    assign o_address_valid_strobe_little_oe = r.ads_oe;
    assign o_mem_direction_read_high        = r.mem_direction_read_high;
    assign o_mem_direction_read_high_oe     = r.mrw_oe;
    assign o_mem_direction_write_high       = r.mem_direction_write_high;
    assign o_mem_direction_write_high_oe    = r.mwr_oe;

endmodule

// ===== core/sbp_bus_pins.sv
// System bus pin sequencer: master cycles, slave register reads, strap mode
// Function
// [RULE1] Strap high selects big endian, low little endian, and the strobe convention.
// [RULE2] Strap 1 uses each dual pin's first meaning, strap 0 its second.
// [RULE3] Master moves 16-bit data on low lines, 32-bit data on all lines.
// [RULE4] Slave register reads drive only the low sixteen data lines.
// [RULE5] Address pins driven only while the bus is held, released otherwise.
// [RULE6] Word aligned transfers; no byte select, 23 significant address lines.
// [RULE7] Host drives the six register select lines to pick a register.
// [RULE8] Big endian: address strobe falls when status and address are valid.
// [RULE9] Big endian: address strobe rises to end the memory cycle.
// [RULE10] Little endian: address strobe rises when status and address are valid.
// [RULE11] While holding the bus, drive a memory direction output.
// [RULE12] Big endian: direction output high for reads, low for writes.
// [RULE13] Little endian: direction output low for reads, high for writes.
// [RULE14] Data lines released unless driving write data or a slave read.
`timescale 1ns/100ps
module sbp_bus_pins (
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_reset,
    input  wire logic                           i_endian_convention_select,
    input  wire logic [sbp_pkg::SEL_W-1:0]      i_register_select_lines,
    input  wire logic                           i_slave_read_sel,
    input  wire logic [sbp_pkg::DATA_W-1:0]     i_system_data_lines,
    output logic      [sbp_pkg::DATA_W-1:0]     o_system_data_lines,
    output logic                                o_system_data_lo_oe,
    output logic                                o_system_data_hi_oe,
    output logic      [sbp_pkg::PIN_ADDR_W-1:0] o_dma_address_lines,
    output logic                                o_dma_address_oe,
    output logic                                o_address_valid_strobe_big,
    output logic                                o_address_valid_strobe_big_oe,
    output logic                                o_address_valid_strobe_little,
    output logic                                o_address_valid_strobe_little_oe,
    output logic                                o_mem_direction_read_high,
    output logic                                o_mem_direction_read_high_oe,
    output logic                                o_mem_direction_write_high,
    output logic                                o_mem_direction_write_high_oe,
    input  wire logic                           i_bus_owned,
    input  wire logic                           i_xfer_req,
    input  wire logic                           i_xfer_write,
    input  wire logic                           i_xfer_wide,
    input  wire logic [sbp_pkg::ADDR_W-1:0]     i_xfer_addr,
    input  wire logic [sbp_pkg::DATA_W-1:0]     i_xfer_wdata,
    output logic                                o_xfer_done,
    output logic      [sbp_pkg::DATA_W-1:0]     o_xfer_rdata,
    output logic      [sbp_pkg::SEL_W-1:0]      o_reg_index,
    input  wire logic [sbp_pkg::HALF_W-1:0]     i_reg_rdata
);

    sbp_pkg::sbp_core_t r;
    sbp_pkg::sbp_core_t n;
    sbp_strb_if         strb ();
    logic               start;

    // Request taken only from idle with the bus held
    assign start = (r.phase == sbp_pkg::SBP_IDLE) && i_xfer_req && i_bus_owned;

    // Next state
    always_comb begin
        n         = r;
        n.done    = 1'b0;
        // Pin synchronisers, first stage feeds only the second
        n.mode_s1 = i_endian_convention_select;
        n.mode_s2 = r.mode_s1;
        n.sel_s1  = i_register_select_lines;
        n.sel_s2  = r.sel_s1;
        n.rd_s1   = i_slave_read_sel;
        n.rd_s2   = r.rd_s1;
        n.din_s1  = i_system_data_lines;
        n.din_s2  = r.din_s1;
        n.reg_index = r.sel_s2;                                   // see [RULE7]
        case (r.phase)
            sbp_pkg::SBP_IDLE: begin
                n.mode_big = r.mode_s2;                           // see [RULE1]
                n.addr_oe  = 1'b0;                                // see [RULE5]
                if (start) begin
                    n.phase    = sbp_pkg::SBP_ADDR;
                    n.is_write = i_xfer_write;
                    n.is_wide  = i_xfer_wide;
                    n.addr     = {sbp_pkg::PAD_W'(0), i_xfer_addr};  // see [RULE6]
                    n.addr_oe  = 1'b1;                            // see [RULE5]
                    n.dout     = i_xfer_wdata;
                    n.lo_oe    = i_xfer_write;                    // see [RULE3]
                    n.hi_oe    = i_xfer_write && i_xfer_wide;     // see [RULE3]
                    n.wait_cnt = sbp_pkg::DATA_WAIT;
                end else if (r.rd_s2) begin
                    n.dout  = {sbp_pkg::HALF_W'(0), i_reg_rdata}; // see [RULE4]
                    n.lo_oe = 1'b1;
                    n.hi_oe = 1'b0;                               // see [RULE4]
                end else begin
                    n.lo_oe = 1'b0;                               // see [RULE14]
                    n.hi_oe = 1'b0;
                end
            end
            sbp_pkg::SBP_ADDR: begin
                n.phase = sbp_pkg::SBP_DATA;
            end
            sbp_pkg::SBP_DATA: begin
                if (r.wait_cnt == 2'h1) begin
                    n.phase = sbp_pkg::SBP_END;
                    n.done  = 1'b1;
                    if (!r.is_write) begin
                        n.rdata = r.is_wide ? r.din_s2                // see [RULE3]
                                            : {sbp_pkg::HALF_W'(0), r.din_s2[15:0]};
                    end
                end else begin
                    n.wait_cnt = r.wait_cnt - 2'h1;
                end
            end
            sbp_pkg::SBP_END: begin
                n.phase   = sbp_pkg::SBP_IDLE;
                n.addr_oe = 1'b0;                                 // see [RULE5]
                n.lo_oe   = 1'b0;                                 // see [RULE14]
                n.hi_oe   = 1'b0;
            end
            default: begin
                n.phase   = sbp_pkg::SBP_IDLE;
                n.addr_oe = 1'b0;
                n.lo_oe   = 1'b0;
                n.hi_oe   = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            r          <= '0;
            r.mode_big <= sbp_pkg::RST_MODE_BIG;
            r.phase    <= sbp_pkg::SBP_IDLE;
        end else begin
            r <= n;
        end
    end

    // Strobe generator hookup
    assign strb.mode_big   = r.mode_big;
    assign strb.owned      = (r.phase != sbp_pkg::SBP_IDLE);      // see [RULE11]
    assign strb.addr_valid = (r.phase == sbp_pkg::SBP_ADDR) || (r.phase == sbp_pkg::SBP_DATA);
    assign strb.is_write   = r.is_write;

    sbp_strobe_gen u_strobe (
        .i_sys_clk                        (i_sys_clk),
        .i_reset                          (i_reset),
        .strb                             (strb),
        .o_address_valid_strobe_big       (o_address_valid_strobe_big),
        .o_address_valid_strobe_big_oe    (o_address_valid_strobe_big_oe),
        .o_address_valid_strobe_little    (o_address_valid_strobe_little),
        .o_address_valid_strobe_little_oe (o_address_valid_strobe_little_oe),
        .o_mem_direction_read_high        (o_mem_direction_read_high),
        .o_mem_direction_read_high_oe     (o_mem_direction_read_high_oe),
        .o_mem_direction_write_high       (o_mem_direction_write_high),
        .o_mem_direction_write_high_oe    (o_mem_direction_write_high_oe)
    );

    // Outputs straight from the state
    assign o_system_data_lines = r.dout;
    assign o_system_data_lo_oe = r.lo_oe;
    assign o_system_data_hi_oe = r.hi_oe;
    assign o_dma_address_lines = r.addr;
    assign o_dma_address_oe    = r.addr_oe;
    assign o_xfer_done         = r.done;
    assign o_xfer_rdata        = r.rdata;
    assign o_reg_index         = r.reg_index;

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    sequence s_start;
        start;
    endsequence

    sequence s_addr_big;
        (r.phase == sbp_pkg::SBP_ADDR) && r.mode_big;
    endsequence

    sequence s_addr_little;
        (r.phase == sbp_pkg::SBP_ADDR) && !r.mode_big;
    endsequence

    property p_addr_drive;
        s_start |=> o_dma_address_oe
            && (o_dma_address_lines == {sbp_pkg::PAD_W'(0), $past(i_xfer_addr)});
    endproperty
    a_addr_drive: assert property (p_addr_drive) else $error("address not driven"); // see [RULE6]

    property p_addr_release;
        (r.phase == sbp_pkg::SBP_END) |=> !o_dma_address_oe;
    endproperty
    a_addr_release: assert property (p_addr_release) else $error("address kept"); // see [RULE5]

    property p_wide_write;
        s_start ##0 (i_xfer_write && i_xfer_wide) |=> o_system_data_lo_oe
            && o_system_data_hi_oe [*3];
    endproperty
    a_wide_write: assert property (p_wide_write) else $error("wide write lanes"); // see [RULE3]

    property p_narrow_write;
        s_start ##0 (i_xfer_write && !i_xfer_wide) |=> o_system_data_lo_oe
            && !o_system_data_hi_oe;
    endproperty
    a_narrow_write: assert property (p_narrow_write) else $error("narrow write lanes"); // see [RULE3]

    property p_slave_read;
        (r.phase == sbp_pkg::SBP_IDLE) && !start && r.rd_s2 |=> o_system_data_lo_oe
            && !o_system_data_hi_oe && (o_system_data_lines[15:0] == $past(i_reg_rdata));
    endproperty
    a_slave_read: assert property (p_slave_read) else $error("slave read lanes"); // see [RULE4]

    property p_data_release;
        (r.phase == sbp_pkg::SBP_IDLE) && !start && !r.rd_s2
            |=> !o_system_data_lo_oe && !o_system_data_hi_oe;
    endproperty
    a_data_release: assert property (p_data_release) else $error("data not released"); // see [RULE14]

    property p_as_fall;
        s_addr_big |=> !o_address_valid_strobe_big && o_address_valid_strobe_big_oe
            && !o_address_valid_strobe_little_oe;
    endproperty
    a_as_fall: assert property (p_as_fall) else $error("big strobe not low"); // see [RULE8] [RULE2]

    property p_as_rise;
        (r.phase == sbp_pkg::SBP_END) && r.mode_big |=> o_address_valid_strobe_big;
    endproperty
    a_as_rise: assert property (p_as_rise) else $error("big strobe not high"); // see [RULE9]

    property p_ads_rise;
        s_addr_little |=> o_address_valid_strobe_little && o_address_valid_strobe_little_oe
            && !o_address_valid_strobe_big_oe;
    endproperty
    a_ads_rise: assert property (p_ads_rise) else $error("little strobe not high"); // see [RULE10] [RULE1]

    property p_dir_big;
        (r.phase == sbp_pkg::SBP_DATA) && r.mode_big |-> o_mem_direction_read_high_oe
            && (o_mem_direction_read_high == !r.is_write);
    endproperty
    a_dir_big: assert property (p_dir_big) else $error("big direction wrong"); // see [RULE12] [RULE11]

    property p_dir_little;
        (r.phase == sbp_pkg::SBP_DATA) && !r.mode_big |-> o_mem_direction_write_high_oe
            && (o_mem_direction_write_high == r.is_write);
    endproperty
    a_dir_little: assert property (p_dir_little) else $error("little direction wrong"); // see [RULE13]

endmodule

// ===== testbench/sbp_mem_model.sv
// Memory side model: answers master reads and resolves the shared data lines
`timescale 1ns/100ps
module sbp_mem_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_owned,
    input  wire logic [31:0] i_rd_word,
    input  wire logic [31:0] i_dev_data,
    input  wire logic        i_dev_lo_oe,
    input  wire logic        i_dev_hi_oe,
    output logic      [31:0] o_bus
);
    logic [31:0] drift_r = 32'h5a5a_0f0f;
    logic [31:0] far;

    // Undriven lines change every cycle, no stale value survives
    always @(posedge i_sys_clk) begin
        drift_r <= ~drift_r;
    end

    // Memory answers reads while the device holds the bus
    assign far = i_owned ? i_rd_word : drift_r;

    // Wire level from the device enables, lane by lane
    assign o_bus[15:0]  = i_dev_lo_oe ? i_dev_data[15:0] : far[15:0];
    assign o_bus[31:16] = i_dev_hi_oe ? i_dev_data[31:16] : far[31:16];
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the system bus pin sequencer
`timescale 1ns/100ps
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        strap = 1'b0;
    logic [5:0]  sel = 6'h00;
    logic        rsel = 1'b0;
    logic        owned = 1'b0;
    logic        req = 1'b0;
    logic        xwr = 1'b0;
    logic        xwide = 1'b0;
    logic [22:0] xaddr = 23'h0;
    logic [31:0] xwd = 32'h0;
    logic [31:0] rd_word = 32'h0;
    logic [31:0] bus, dout, rdata;
    logic [30:0] addr;
    logic [5:0]  ridx;
    logic [15:0] reg_rd;
    logic        lo_oe, hi_oe, a_oe, sb, sb_oe, sl, sl_oe, mem_direction_read_high, mrw_oe, mem_direction_write_high, mwr_oe, done;
    int          fails = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    sbp_bus_pins sbp_bus_pins_i (
        .i_sys_clk(clk), .i_reset(rst), .i_endian_convention_select(strap),
        .i_register_select_lines(sel), .i_slave_read_sel(rsel), .i_system_data_lines(bus),
        .o_system_data_lines(dout), .o_system_data_lo_oe(lo_oe), .o_system_data_hi_oe(hi_oe),
        .o_dma_address_lines(addr), .o_dma_address_oe(a_oe),
        .o_address_valid_strobe_big(sb), .o_address_valid_strobe_big_oe(sb_oe),
        .o_address_valid_strobe_little(sl), .o_address_valid_strobe_little_oe(sl_oe),
        .o_mem_direction_read_high(mem_direction_read_high), .o_mem_direction_read_high_oe(mrw_oe),
        .o_mem_direction_write_high(mem_direction_write_high), .o_mem_direction_write_high_oe(mwr_oe),
        .i_bus_owned(owned), .i_xfer_req(req), .i_xfer_write(xwr), .i_xfer_wide(xwide),
        .i_xfer_addr(xaddr), .i_xfer_wdata(xwd), .o_xfer_done(done), .o_xfer_rdata(rdata),
        .o_reg_index(ridx), .i_reg_rdata(reg_rd));

    sbp_mem_model sbp_mem_model_i (
        .i_sys_clk(clk), .i_owned(owned), .i_rd_word(rd_word), .i_dev_data(dout),
        .i_dev_lo_oe(lo_oe), .i_dev_hi_oe(hi_oe), .o_bus(bus));

    // Register file contents seen by the host, keyed by the synced select
    assign reg_rd = {10'h000, ridx} ^ 16'hc3a5;

    // Clock, 40 ns period
    always #20 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One master cycle in the given convention, direction and width
    task automatic t_master(input logic big, input logic wr, input logic wide);
        logic [22:0] a;
        logic [31:0] d;
        logic        act;
        logic        hold;
        a = {big, wr, wide, 20'h5a3c1};
        d = {8'h9e, 5'h00, big, wr, wide, 16'h7b24};
        strap = big;
        repeat (4) @(negedge clk);
        owned = 1'b1;
        xwr = wr;
        xwide = wide;
        xaddr = a;
        xwd = d;
        rd_word = ~d;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        chk(a_oe, 1'b1, "address at first edge");
        chk(sb_oe | sl_oe, 1'b0, "strobe lags address");
        for (int k = 1; k <= 5; k++) begin
            @(negedge clk);
            act = (k <= 3);
            hold = (k <= 4);
            chk(a_oe, k <= 3, "address enable");
            if (k <= 3) chk(addr, {8'h00, a}, "address");
            chk(lo_oe, wr && k <= 3, "low lane enable");
            chk(hi_oe, wr && wide && k <= 3, "high lane enable");
            if (wr && k <= 3) chk(dout[15:0], d[15:0], "low write data");
            if (wr && wide && k <= 3) chk(dout, d, "wide write data");
            chk(done, k == 3, "done pulse");
            chk(sb_oe, big && hold, "big strobe enable");
            chk(sl_oe, !big && hold, "little strobe enable");
            if (big) chk(sb, !act, "big strobe level");
            if (!big) chk(sl, act, "little strobe level");
            chk(mrw_oe, big && hold, "read-high direction enable");
            chk(mwr_oe, !big && hold, "write-high direction enable");
            if (big && act) chk(mem_direction_read_high, !wr, "read-high direction");
            if (!big && act) chk(mem_direction_write_high, wr, "write-high direction");
            if (!wr && k == 3)
                chk(rdata, wide ? ~d : {16'h0000, ~d[15:0]}, "read data");
        end
        owned = 1'b0;
        $display("master big=%0d write=%0d wide=%0d done", big, wr, wide);
    endtask

    // Host register read answers on the low lanes only
    task automatic t_slave();
        sel = 6'h2b;
        rsel = 1'b1;
        repeat (5) @(negedge clk);
        chk(ridx, 6'h2b, "register index");
        chk(lo_oe, 1'b1, "slave low enable");
        chk(hi_oe, 1'b0, "slave high enable");
        chk(dout[15:0], {10'h000, 6'h2b} ^ 16'hc3a5, "slave data");
        chk(a_oe, 1'b0, "address released in slave read");
        rsel = 1'b0;
        repeat (5) @(negedge clk);
        chk(lo_oe, 1'b0, "slave release");
        $display("slave read done");
    endtask

    // Request without the bus is ignored
    task automatic t_refused();
        owned = 1'b0;
        req = 1'b1;
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            chk(a_oe, 1'b0, "address without bus");
            chk(done, 1'b0, "done without bus");
            chk(lo_oe | hi_oe, 1'b0, "data without bus");
        end
        req = 1'b0;
        $display("refused request done");
    endtask

    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk(a_oe | lo_oe | hi_oe | sb_oe | sl_oe, 1'b0, "released after reset");
        for (int m = 0; m < 8; m++) begin
            t_master(m[2], m[1], m[0]);
        end
        t_slave();
        t_refused();
        report_and_stop();
    end
endmodule
